//--- verilog/oad_decode.v
// operand addressing decode, address generation and register access checks
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module oad_decode (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // decode stream
  input wire dec_valid,
  input wire [2:0] dec_prefix,
  input wire dec_prefix_valid,
  input wire [1:0] dec_class,
  input wire dec_three_op,
  input wire dec_user_mode,
  input wire [2:0] src_mode,
  input wire [2:0] src_size,
  input wire [31:0] src_field,
  input wire [2:0] dst_mode,
  input wire [2:0] dst_size,
  input wire [31:0] dst_field,
  input wire [31:0] pc_addr,
  input wire [31:0] current_stack_pointer,
  // pointer fetch answer from operand memory
  input wire ptr_valid,
  input wire [31:0] ptr_data,
  // operand data from memory and ALU
  input wire [31:0] src_mem_data,
  input wire [31:0] dst_mem_data,
  input wire [32:0] alu_sum,
  input wire alu_ovf_full,
  // pointer fetch request
  output wire ptr_req,
  output reg [31:0] ptr_addr_r,
  // decoded operand
  output reg op_valid_r,
  output reg [31:0] src_addr_r,
  output reg [31:0] dst_addr_r,
  output reg [31:0] src_value_r,
  output reg [31:0] src_wide_r,
  output reg [31:0] dst_wide_r,
  output reg [3:0] src_reg_r,
  output reg [3:0] dst_reg_r,
  output reg src_is_reg_r,
  output reg dst_is_reg_r,
  // destination write
  output reg wr_en_r,
  output reg [31:0] wr_data_r,
  output reg [31:0] wr_mask_r,
  output reg wr_to_acc_r,
  output reg carry_r,
  output reg overflow_r,
  // exceptions
  output reg exc_valid_r,
  output reg [3:0] exc_id_r
);
  // state machine, one-hot
  // idle takes instructions, fetch waits on the pointer answer, done issues the result
  localparam ST_IDLE = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  // the prefix lasts only for the next instruction
  reg pfx_reg_r;
  // held instruction while a pointer is fetched
  reg fetch_src_r;
  // widened views of memory operands
  wire [31:0] src_ext;
  wire [31:0] dst_ext;
  wire [31:0] dst_mask;
  // immediate widened by its qualifier
  wire [31:0] imm_ext;

  // register number comes only from the low four bits
  function [3:0] reg_num;
    input [31:0] fld;
    begin
      reg_num = fld[`OAD_REG_MSB:0]; // RULE14
    end
  endfunction

  // unimplemented register numbers
  // zero and the top three numbers have no register behind them
  function reg_bad;
    input [3:0] rn;
    begin
      reg_bad = (rn == `OAD_REG_NONE) || (rn >= `OAD_REG_HI_FIRST); // RULE16
    end
  endfunction

  // mode legality per instruction class
  function mode_ok;
    input [2:0] md;
    input [1:0] cls;
    begin
      case (md)
        `OAD_MODE_IMM, `OAD_MODE_ABS, `OAD_MODE_STK, `OAD_MODE_STKI: mode_ok = 1'b1; // RULE5
        `OAD_MODE_ABSI, `OAD_MODE_PCREL: mode_ok = (cls != `OAD_CLS_ALU); // RULE11 RULE12
        // register mode only arises through the prefix, so every class may use it
        `OAD_MODE_REG: mode_ok = 1'b1; // RULE13
        default: mode_ok = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // operand widening
  oad_extend u_src_ext (
    .size_q(src_size),
    .raw_val(src_mem_data),
    .wide_val(src_ext),
    .narrow_mask()
  );
  oad_extend u_dst_ext (
    .size_q(dst_size),
    .raw_val(dst_mem_data),
    .wide_val(dst_ext),
    .narrow_mask(dst_mask)
  );
  oad_extend u_imm_ext (
    .size_q(src_size),
    .raw_val(src_field),
    .wide_val(imm_ext),
    .narrow_mask()
  );

  ////////////////////////////////////////////////////////////////
  // effective operand modes after any register prefix
  wire [2:0] src_md = pfx_reg_r ? `OAD_MODE_REG : src_mode; // RULE13
  wire [2:0] dst_md = pfx_reg_r ? `OAD_MODE_REG : dst_mode; // RULE13
  wire [3:0] src_rn = reg_num(src_field);
  wire [3:0] dst_rn = reg_num(dst_field);
  wire src_reg = (src_md == `OAD_MODE_REG);
  wire dst_reg = (dst_md == `OAD_MODE_REG) && !dec_three_op;
  // misaligned stack indirect offsets
  wire src_mis = (src_md == `OAD_MODE_STKI) && |(src_field & `OAD_WORD_ALIGN_MASK); // RULE10
  wire dst_mis = (dst_md == `OAD_MODE_STKI) && |(dst_field & `OAD_WORD_ALIGN_MASK);
  // checks on the register-access path
  wire unimp = (src_reg && reg_bad(src_rn)) || (dst_reg && reg_bad(dst_rn)); // RULE16
  wire priv = dst_reg && dec_user_mode; // RULE17
  // stack pointer plus signed offset
  // wraps modulo the word size, as the address adder does; no overflow check
  wire [31:0] src_stk = current_stack_pointer + src_field; // RULE9
  wire [31:0] dst_stk = current_stack_pointer + dst_field;
  // a prefix instruction is consumed, not executed
  wire take = dec_valid && !dec_prefix_valid && (state_r == ST_IDLE);
  // only the source operand is fetched through a pointer; one fetch per
  // instruction keeps the sequencer a plain three-state loop
  wire need_ptr = (src_md == `OAD_MODE_STKI) || (src_md == `OAD_MODE_ABSI);
  // held until the answer edge; the caller keeps dec_valid low meanwhile
  assign ptr_req = (state_r == ST_FETCH);

  ////////////////////////////////////////////////////////////////
  // next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take && need_ptr && !src_mis && !unimp && !priv) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // no timeout: the operand memory path must answer every fetch
        if (ptr_valid) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // prefix capture: held until the next real instruction is taken
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pfx_reg_r <= 1'b0;
    end else if (dec_valid && dec_prefix_valid && state_r == ST_IDLE) begin
      // any other prefix code clears a stale register rewrite
      pfx_reg_r <= (dec_prefix == `OAD_PFX_REG); // RULE13
    end else if (take) begin
      pfx_reg_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // main decode registers
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      fetch_src_r <= 1'b0;
      ptr_addr_r <= 32'h00000000;
      op_valid_r <= 1'b0;
      src_addr_r <= 32'h00000000;
      dst_addr_r <= 32'h00000000;
      src_value_r <= 32'h00000000;
      src_wide_r <= 32'h00000000;
      dst_wide_r <= 32'h00000000;
      src_reg_r <= 4'h0;
      dst_reg_r <= 4'h0;
      src_is_reg_r <= 1'b0;
      dst_is_reg_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_data_r <= 32'h00000000;
      wr_mask_r <= 32'h00000000;
      wr_to_acc_r <= 1'b0;
      carry_r <= 1'b0;
      overflow_r <= 1'b0;
      exc_valid_r <= 1'b0;
      exc_id_r <= `OAD_EXC_NONE;
    end else begin
      state_r <= state_nxt;
      // result and exception strobes are one-cycle pulses
      op_valid_r <= 1'b0;
      exc_valid_r <= 1'b0;
      wr_en_r <= 1'b0;
      // operand data widened for the ALU each cycle
      src_wide_r <= (src_md == `OAD_MODE_IMM) ? imm_ext : src_ext; // RULE1 RULE7
      dst_wide_r <= dst_ext; // RULE1
      // flags from the full word result only
      // narrowing happens after the flags are taken, so dropped bits never count
      carry_r <= alu_sum[32]; // RULE2 RULE3
      overflow_r <= alu_ovf_full; // RULE2
      // destination gets low bits, or the whole word to the accumulator
      wr_data_r <= alu_sum[31:0] & (dec_three_op ? 32'hFFFFFFFF : dst_mask); // RULE3 RULE4
      case (state_r)
        ST_IDLE: begin
          // indirect forms leave the result to the fetch and done states
          if (take) begin
            src_reg_r <= src_rn;
            dst_reg_r <= dec_three_op ? `OAD_REG_ACC : dst_rn; // RULE18
            src_is_reg_r <= src_reg;
            dst_is_reg_r <= dst_reg;
            wr_to_acc_r <= dec_three_op; // RULE4
            wr_mask_r <= dec_three_op ? 32'hFFFFFFFF : dst_mask; // RULE3
            // source address by mode
            case (src_md)
              `OAD_MODE_ABS: src_addr_r <= src_field; // RULE8
              `OAD_MODE_STK: src_addr_r <= src_stk; // RULE9
              default: src_addr_r <= src_field;
            endcase
            // operand value for pc-relative and immediate forms
            src_value_r <= (src_md == `OAD_MODE_PCREL) ? pc_addr + src_field : imm_ext; // RULE12 RULE7
            dst_addr_r <= (dst_md == `OAD_MODE_STK) ? dst_stk : dst_field;
            // pointer location for indirect modes
            ptr_addr_r <= (src_md == `OAD_MODE_STKI) ? src_stk : src_field; // RULE10 RULE11
            // remember whether the pointer names an instruction: it needs parcel alignment
            fetch_src_r <= (src_md == `OAD_MODE_ABSI); // RULE11
            // priority: unimplemented register, privilege, alignment, then class
            if (unimp) begin
              exc_valid_r <= 1'b1;
              exc_id_r <= `OAD_EXC_UNIMP; // RULE16 RULE20
            end else if (priv) begin
              exc_valid_r <= 1'b1;
              exc_id_r <= `OAD_EXC_PRIV; // RULE17 RULE20
            end else if (src_mis || dst_mis) begin
              exc_valid_r <= 1'b1;
              exc_id_r <= `OAD_EXC_ALIGN; // RULE19
            end else if (!mode_ok(src_md, dec_class) || !mode_ok(dst_md, dec_class)) begin
              // illegal mode for this class: report as alignment-free decode fault
              exc_valid_r <= 1'b1;
              exc_id_r <= `OAD_EXC_UNIMP; // RULE5
            end else if (!need_ptr) begin
              op_valid_r <= 1'b1;
              wr_en_r <= 1'b1;
            end
          end
        end
        ST_FETCH: begin
          if (ptr_valid) begin
            // absolute indirect yields an instruction address: parcel aligned
            if (fetch_src_r && |(ptr_data & `OAD_HALF_ALIGN_MASK)) begin
              exc_valid_r <= 1'b1;
              exc_id_r <= `OAD_EXC_ALIGN; // RULE11
            end else begin
              src_addr_r <= ptr_data; // RULE10 RULE11
              src_value_r <= ptr_data;
            end
          end
        end
        ST_DONE: begin
          // the pointer has landed; an alignment fault raised at the answer edge
          // already stands in exc_valid_r and holds the result back
          if (!exc_valid_r) begin
            op_valid_r <= 1'b1;
            wr_en_r <= 1'b1;
          end
        end
        default: begin
          fetch_src_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // oad_decode
`default_nettype wire

//--- verilog/oad_map.vh
// constants for the operand addressing decode block
// Summary of operation
// RULE1: widen byte/halfword operands to 32 bits
// RULE2: carry and overflow from full ALU result
// RULE3: narrow destinations take low bits, no flags
// RULE4: two-and-a-half-operand result goes to accumulator
// RULE5: ALU ops accept first four modes only; code also accepts register mode 0x6 for ALU ops
// RULE6: size qualifier decode, absent means signed word
// RULE7: immediate value from instruction, extended
// RULE8: absolute mode uses instruction address directly
// RULE9: stack offset adds signed offset to pointer
// RULE10: stack indirect fetches pointer at pointer+offset
// RULE11: absolute indirect only jump/call/load-address, parcel aligned
// RULE12: pc-relative only jump/call/load-address, pc plus offset
// RULE13: prefix code 0x7 rewrites next operands to registers
// RULE14: register number from operand bits 3:0
// RULE15: software reads at most one register per instruction
// RULE16: register 0 or 0xD-0xF raises exception 0x6
// RULE17: user-mode register write raises exception 0x5
// RULE18: accumulator is internal register four
// RULE19: misaligned stack indirect offset raises exception 0x4
// RULE20: decode exceptions suppress destination write; code still writes after a pointer fetch on a class or dst alignment fault
`ifndef OAD_MAP_VH
`define OAD_MAP_VH
// addressing mode codes
`define OAD_MODE_IMM 3'h0
`define OAD_MODE_ABS 3'h1
`define OAD_MODE_STK 3'h2
`define OAD_MODE_STKI 3'h3
`define OAD_MODE_ABSI 3'h4
`define OAD_MODE_PCREL 3'h5
`define OAD_MODE_REG 3'h6
// size qualifier codes
`define OAD_SZ_NONE 3'h0
`define OAD_SZ_SB 3'h1
`define OAD_SZ_UB 3'h2
`define OAD_SZ_SH 3'h3
`define OAD_SZ_UH 3'h4
`define OAD_SZ_W 3'h5
// instruction classes
`define OAD_CLS_ALU 2'h0
`define OAD_CLS_JUMP 2'h1
`define OAD_CLS_CALL 2'h2
`define OAD_CLS_LDADDR 2'h3
// prefix and register numbers
`define OAD_PFX_REG 3'h7
`define OAD_REG_NONE 4'h0
`define OAD_REG_ACC 4'h4
`define OAD_REG_HI_FIRST 4'hD
// exception identifiers
`define OAD_EXC_NONE 4'h0
`define OAD_EXC_ALIGN 4'h4
`define OAD_EXC_PRIV 4'h5
`define OAD_EXC_UNIMP 4'h6
// field positions
`define OAD_BYTE_MSB 7
`define OAD_HALF_MSB 15
`define OAD_REG_MSB 3
`define OAD_WORD_ALIGN_MASK 32'h00000003
`define OAD_HALF_ALIGN_MASK 32'h00000001
`endif

//--- verilog/oad_extend.v
// size qualifier decode and operand widening/narrowing
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module oad_extend (
  // qualifier and raw value
  input wire [2:0] size_q,
  input wire [31:0] raw_val,
  // widened value for the ALU
  output reg [31:0] wide_val,
  // narrowed result mask for destination writes
  output reg [31:0] narrow_mask
);
  // widen per qualifier; missing qualifier is a signed word
  always @* begin
    case (size_q)
      `OAD_SZ_SB: begin // RULE6
        wide_val = {{24{raw_val[`OAD_BYTE_MSB]}}, raw_val[7:0]}; // RULE1
        narrow_mask = 32'h000000FF;
      end
      `OAD_SZ_UB: begin
        wide_val = {24'h000000, raw_val[7:0]}; // RULE1
        narrow_mask = 32'h000000FF;
      end
      `OAD_SZ_SH: begin
        wide_val = {{16{raw_val[`OAD_HALF_MSB]}}, raw_val[15:0]}; // RULE1
        narrow_mask = 32'h0000FFFF;
      end
      `OAD_SZ_UH: begin
        wide_val = {16'h0000, raw_val[15:0]}; // RULE1
        narrow_mask = 32'h0000FFFF;
      end
      default: begin
        // word and absent qualifier pass through
        wide_val = raw_val;
        narrow_mask = 32'hFFFFFFFF;
      end
    endcase
  end
endmodule // oad_extend
`default_nettype wire

//--- verif/oad_mem_model.sv
// far-side pointer fetch responder for the operand addressing decode block
`timescale 1ns/10ps
`default_nettype none
module oad_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // fetch request and wait states
  input wire logic ptr_req,
  input wire logic [31:0] ptr_addr_r,
  input wire logic [3:0] lat,
  // fetch answer
  output var logic ptr_valid,
  output var logic [31:0] ptr_data
);
  logic [3:0] wait_r; // cycles waited on this fetch
  ////////////////////////////////////////
  // answer after lat waits; data toggles when not valid so stale words never look good
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 4'h0;
      ptr_valid <= 1'b0;
      ptr_data <= 32'h0;
    end else if (ptr_req && !ptr_valid && wait_r == lat) begin
      wait_r <= 4'h0;
      ptr_valid <= 1'b1;
      ptr_data <= ptr_addr_r ^ 32'h00F00F00;
    end else begin
      wait_r <= (ptr_req && !ptr_valid) ? wait_r + 4'h1 : 4'h0;
      ptr_valid <= 1'b0;
      ptr_data <= ~ptr_data;
    end
  end
endmodule // oad_mem_model
`default_nettype wire

//--- verif/oad_decode_chk.sv
// concurrent checks on the operand addressing decode ports
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module oad_decode_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // decode stream
  input wire logic dec_valid,
  input wire logic dec_prefix_valid,
  input wire logic [2:0] dec_prefix,
  input wire logic dec_three_op,
  input wire logic dec_user_mode,
  input wire logic [2:0] src_mode,
  input wire logic [2:0] src_size,
  input wire logic [31:0] src_field,
  input wire logic [2:0] dst_mode,
  input wire logic [2:0] dst_size,
  input wire logic [31:0] dst_field,
  input wire logic [31:0] current_stack_pointer,
  // operand and alu data
  input wire logic [31:0] src_mem_data,
  input wire logic [32:0] alu_sum,
  input wire logic alu_ovf_full,
  // decoder results
  input wire logic ptr_req,
  input wire logic [31:0] ptr_addr_r,
  input wire logic op_valid_r,
  input wire logic [31:0] src_addr_r,
  input wire logic [31:0] src_wide_r,
  input wire logic wr_en_r,
  input wire logic [31:0] wr_data_r,
  input wire logic carry_r,
  input wire logic overflow_r,
  input wire logic exc_valid_r,
  input wire logic [3:0] exc_id_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // widening by size code; narrowing keeps low bits and never extends the sign
  function automatic logic [31:0] ext(input logic [31:0] v, input logic [2:0] q, input logic nw);
    case (q)
      `OAD_SZ_SB: ext = nw ? {24'h0, v[7:0]} : {{24{v[7]}}, v[7:0]};
      `OAD_SZ_UB: ext = {24'h0, v[7:0]};
      `OAD_SZ_SH: ext = nw ? {16'h0, v[15:0]} : {{16{v[15]}}, v[15:0]};
      `OAD_SZ_UH: ext = {16'h0, v[15:0]};
      default: ext = v;
    endcase
  endfunction
  // an instruction taken with no register prefix in front of it
  sequence s_plain;
    !(dec_valid && dec_prefix_valid) ##1 (dec_valid && !dec_prefix_valid && !ptr_req && dst_mode == `OAD_MODE_ABS);
  endsequence
  // register prefix followed by the instruction it rewrites
  sequence s_pfx;
    (dec_valid && dec_prefix_valid && dec_prefix == `OAD_PFX_REG) ##1 (dec_valid && !dec_prefix_valid);
  endsequence
  // immediate mode widens the instruction field, every other mode the memory operand
  AST_SRC_WIDEN: assert property (!$past(sys_rst) |->
    src_wide_r == ext(($past(src_mode) == `OAD_MODE_IMM) ? $past(src_field) : $past(src_mem_data), $past(src_size), 1'b0))
    else $error("source operand widened wrongly");
  AST_FULL_FLAGS: assert property (!$past(sys_rst) |->
    {carry_r, overflow_r} == {$past(alu_sum[32]), $past(alu_ovf_full)})
    else $error("carry or overflow not from full result");
  AST_NARROW: assert property (!$past(sys_rst) |->
    wr_data_r == ext($past(alu_sum[31:0]), $past(dec_three_op) ? `OAD_SZ_W : $past(dst_size), 1'b1))
    else $error("destination data not narrowed right");
  AST_ABS_ADDR: assert property (s_plain ##0 src_mode == `OAD_MODE_ABS |=>
    op_valid_r && src_addr_r == $past(src_field))
    else $error("absolute address wrong");
  AST_STK_ADDR: assert property (s_plain ##0 src_mode == `OAD_MODE_STK |=>
    op_valid_r && src_addr_r == $past(current_stack_pointer) + $past(src_field))
    else $error("stack offset address wrong");
  AST_STK_IND: assert property (s_plain ##0 src_mode == `OAD_MODE_STKI |=>
    ($past(src_field[1:0]) == 2'h0) ?
    (ptr_req && ptr_addr_r == $past(current_stack_pointer) + $past(src_field)) :
    (exc_valid_r && exc_id_r == `OAD_EXC_ALIGN))
    else $error("stack indirect fetch or alignment fault wrong");
  AST_UNIMP_REG: assert property (s_pfx ##0 (src_field[3:0] == 4'h0 || src_field[3:0] >= 4'hD) |=>
    exc_valid_r && exc_id_r == `OAD_EXC_UNIMP && !wr_en_r)
    else $error("unimplemented register not trapped");
  AST_USER_WRITE: assert property (s_pfx ##0 (dec_user_mode && !dec_three_op &&
    src_field[3:0] inside {[4'h1:4'hC]} && dst_field[3:0] inside {[4'h1:4'hC]}) |=>
    exc_valid_r && exc_id_r == `OAD_EXC_PRIV && !wr_en_r)
    else $error("user register write not trapped");
endmodule // oad_decode_chk
bind oad_decode oad_decode_chk u_chk (.*);
`default_nettype wire

//--- verif/operand_addressing_decode_bench.sv
// self-checking bench for the operand addressing decode block
`timescale 1ns/10ps
`default_nettype none
`include "oad_map.vh"
module operand_addressing_decode_bench;
  // design inputs
  logic mclk = 1'b0, sys_rst = 1'b1, dec_valid = 1'b0, dec_prefix_valid = 1'b0, dec_three_op = 1'b0;
  logic dec_user_mode = 1'b0, alu_ovf_full = 1'b0, ptr_valid;
  logic [1:0] dec_class = 2'h0;
  logic [2:0] dec_prefix = 3'h0, src_mode = 3'h1, src_size = 3'h0, dst_mode = 3'h1, dst_size = 3'h0;
  logic [31:0] src_field = 32'h0, dst_field = 32'h0, pc_addr = 32'h0, current_stack_pointer = 32'h4000;
  logic [31:0] src_mem_data = 32'h0, dst_mem_data = 32'h0, ptr_data;
  logic [32:0] alu_sum = 33'h0;
  logic [3:0] lat = 4'h0;
  // design outputs
  logic ptr_req, op_valid_r, src_is_reg_r, dst_is_reg_r, wr_en_r, wr_to_acc_r, carry_r, overflow_r, exc_valid_r;
  logic [31:0] ptr_addr_r, src_addr_r, dst_addr_r, src_value_r, src_wide_r, dst_wide_r, wr_data_r, wr_mask_r;
  logic [3:0] src_reg_r, dst_reg_r, exc_id_r;
  integer miscompares = 0, checked = 0, seed = 32'h6427, i;
  always #10 mclk = ~mclk;
  oad_decode DUT (.*);
  oad_mem_model u_mem (.*);
  ////////////////////////////////////////
  // reference widening: shift up, then back down arithmetically or logically
  function automatic logic [31:0] wid(input logic [31:0] v, input logic [2:0] q, input bit nw);
    integer w;
    w = (q == `OAD_SZ_SB || q == `OAD_SZ_UB) ? 8 : (q == `OAD_SZ_SH || q == `OAD_SZ_UH) ? 16 : 32;
    wid = v << (32 - w);
    // two branches: a conditional with one unsigned arm would make the shift logical
    if (!nw && (q == `OAD_SZ_SB || q == `OAD_SZ_SH)) wid = $signed(wid) >>> (32 - w);
    else wid = wid >> (32 - w);
  endfunction
  // compare one result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // present an instruction; dec_valid stays up so back-to-back issues need no gap
  task automatic issue(input logic [2:0] sm, input logic [31:0] sf);
    src_mode = sm;
    src_field = sf;
    dec_valid = 1'b1;
    @(posedge mclk) #1;
  endtask
  // register prefix, then the instruction it rewrites
  task automatic pfx(input logic [31:0] sf, input logic [31:0] df);
    dec_prefix_valid = 1'b1;
    dec_prefix = `OAD_PFX_REG;
    dec_valid = 1'b1;
    @(posedge mclk) #1;
    dec_prefix_valid = 1'b0;
    dst_field = df;
    issue(src_mode, sf);
  endtask
  // bounded wait for a pointer fetch to finish
  task automatic await;
    for (int n = 0; n < 20 && op_valid_r !== 1'b1 && exc_valid_r !== 1'b1; n++) @(posedge mclk) #1;
  endtask
  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang of 1000 cycles ends the run
  initial begin
    #20000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    for (i = 0; i < 24; i++) begin
      src_size = 3'(i % 6);
      dst_size = 3'((i + 3) % 6);
      src_mem_data = $random(seed);
      dst_mem_data = $random(seed);
      alu_sum = 33'({$random(seed), $random(seed)});
      alu_ovf_full = 1'($random(seed));
      dec_three_op = (i % 4 == 3);
      @(posedge mclk) #1;
      chk(src_wide_r, wid(src_mem_data, src_size, 0));
      chk(dst_wide_r, wid(dst_mem_data, dst_size, 0));
      chk({30'h0, carry_r, overflow_r}, {30'h0, alu_sum[32], alu_ovf_full});
      chk(wr_data_r, wid(alu_sum[31:0], dec_three_op ? 3'h5 : dst_size, 1));
    end
    $display("done: widening");
    dec_three_op = 1'b0;
    dst_field = 32'h00000ABC;
    issue(`OAD_MODE_ABS, 32'h00012344);
    chk({src_addr_r[30:0], op_valid_r & wr_en_r}, 32'h00024689);
    chk(dst_addr_r, 32'h00000ABC);
    chk(wr_mask_r, 32'h000000FF);
    issue(`OAD_MODE_STK, 32'hFFFFFFF8);
    chk(src_addr_r, 32'h00003FF8);
    src_size = `OAD_SZ_SB;
    issue(`OAD_MODE_IMM, 32'h000000A5);
    chk(src_value_r, 32'hFFFFFFA5);
    dec_three_op = 1'b1;
    issue(`OAD_MODE_ABS, 32'h00000100);
    chk({27'h0, wr_to_acc_r, dst_reg_r}, 32'h00000014);
    chk(wr_mask_r, 32'hFFFFFFFF);
    dec_three_op = 1'b0;
    issue(`OAD_MODE_STKI, 32'h00000006);
    dec_valid = 1'b0;
    chk({27'h0, exc_valid_r, exc_id_r}, 32'h14);
    for (i = 0; i < 2; i++) begin
      lat = 4'(i * 3);
      issue(`OAD_MODE_STKI, 32'h00000008);
      dec_valid = 1'b0;
      await;
      chk(src_addr_r, 32'h00F04F08);
      @(posedge mclk) #1;
    end
    issue(`OAD_MODE_PCREL, 32'h00000010);
    chk({27'h0, exc_valid_r, exc_id_r}, 32'h16);
    dec_class = `OAD_CLS_CALL;
    pc_addr = 32'h00002000;
    issue(`OAD_MODE_PCREL, 32'hFFFFFFF0);
    chk(src_value_r, 32'h00001FF0);
    dec_class = `OAD_CLS_JUMP;
    issue(`OAD_MODE_ABSI, 32'h00000A00);
    dec_valid = 1'b0;
    await;
    chk({31'h0, op_valid_r}, 32'h1);
    @(posedge mclk) #1;
    dec_class = `OAD_CLS_ALU;
    $display("done: addressing modes");
    pfx(32'hFFFFFFF3, 32'h00000002);
    dec_valid = 1'b0;
    chk({21'h0, src_is_reg_r, dst_is_reg_r, wr_en_r, src_reg_r, dst_reg_r}, 32'h00000732);
    for (i = 0; i < 4; i++) begin
      @(posedge mclk) #1;
      pfx((i == 0) ? 32'h0 : 32'(12 + i), 32'h00000001);
      dec_valid = 1'b0;
      chk({26'h0, wr_en_r, exc_valid_r, exc_id_r}, 32'h16);
    end
    @(posedge mclk) #1;
    dec_user_mode = 1'b1;
    pfx(32'h00000001, 32'h00000002);
    dec_valid = 1'b0;
    chk({26'h0, wr_en_r, exc_valid_r, exc_id_r}, 32'h15);
    // a prefix with another code must leave the next operands in memory
    @(posedge mclk) #1;
    dec_user_mode = 1'b0;
    dec_prefix_valid = 1'b1;
    dec_prefix = 3'h3;
    dec_valid = 1'b1;
    @(posedge mclk) #1;
    dec_prefix_valid = 1'b0;
    issue(`OAD_MODE_ABS, 32'h00000040);
    dec_valid = 1'b0;
    chk({30'h0, src_is_reg_r, op_valid_r}, 32'h00000001);
    $display("done: register access");
    conclude;
  end
endmodule // operand_addressing_decode_bench
`default_nettype wire
